// ### include/pfp_defines.vh
// Purpose: constants of the parallel flash program port
// Assumes: clock of 200 MHz (5 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef PFP_DEFINES_VH
`define PFP_DEFINES_VH
`define PFP_CLK_MHZ 200
`define PFP_CMD_ERASE 4'h1
`define PFP_CMD_LOAD_PAGE 4'hD
`define PFP_CMD_CODE_WRITE 4'hE
`define PFP_CMD_CODE_READ 4'hC
`define PFP_CMD_SIG_WRITE 4'h0
`define PFP_CMD_SIG_READ 4'h8
`define PFP_CMD_FUSE_WRITE 4'hF
`define PFP_CMD_FUSE_READ 4'h3
`define PFP_FUSE_BYPASS_BIT 7
`define PFP_FUSE_USER_ROW_BIT 6
`define PFP_FUSE_DOUBLE_BIT 5
`define PFP_FUSE_SERIAL_BIT 4
`define PFP_LOCK_TWO_BIT 1
`define PFP_LOCK_ONE_BIT 0
`define PFP_FUSE_RESET 8'hF3
`define PFP_ERASED 8'hFF
`define PFP_PAGE_USER 8'h00
`define PFP_PAGE_MAKER 8'h01
`define PFP_LOAD_WAIT_US 150
`define PFP_WRITE_MS 2
`define PFP_ERASE_MS 4
`define PFP_LOAD_WAIT_CYC (`PFP_LOAD_WAIT_US * `PFP_CLK_MHZ)
`define PFP_WRITE_CYC (`PFP_WRITE_MS * 1000 * `PFP_CLK_MHZ)
`define PFP_ERASE_CYC (`PFP_ERASE_MS * 1000 * `PFP_CLK_MHZ)
`endif

// ### hdl/pfp_mem.v
// Purpose: byte memory with registered read data
// Assumes: one write and one read port access per cycle
// Notes: no reset on contents; erase is done by the sequencer
`timescale 1ns/1ps
module pfp_mem #(
  parameter AW = 12
) (
  // clock
  input wire clock_in,
  // write side
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  // read side
  input wire [AW-1:0] rd_addr_in,
  output reg [7:0] rd_data_out
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // pfp_mem

// ### hdl/pfp_port.v
// Purpose: parallel programming port sequencer of the on-chip code flash
// Assumes: all pins synchronous to clock_in; high-voltage detect is a level input
// Notes: erase walks all locations one per cycle, inside the timed window
`timescale 1ns/1ps
`include "pfp_defines.vh"
module pfp_port #(
  parameter PAGE_BITS = 7,
  parameter LOAD_WAIT_CYC = `PFP_LOAD_WAIT_CYC,
  parameter WRITE_CYC = `PFP_WRITE_CYC,
  parameter ERASE_CYC = `PFP_ERASE_CYC,
  parameter [7:0] MAKER_ID0 = 8'h5A, // arbitrary value
  parameter [7:0] MAKER_ID1 = 8'hA5  // arbitrary value
) (
  // clock and reset
  input wire clock_in,
  input wire nrst_in,
  // programming level on the reset pin
  input wire high_voltage_in,
  // control pins
  input wire [3:0] command_select_code_in,
  input wire offset_step_pin_in,
  input wire load_strobe_pin_n_in,
  // data port
  input wire [7:0] data_port_in,
  output reg [7:0] data_port_out,
  output reg data_port_oe_out,
  // open-drain busy pin
  output reg busy_output_pin_out,
  output reg busy_output_pin_oe_out
);
  localparam AW = PAGE_BITS + 5;
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_PROG = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg hv_q;
  reg step_q;
  reg strobe_n_q;
  reg [3:0] cmd_q;
  reg [7:0] page_q;
  reg [4:0] offset_q;
  reg [1:0] state_q;
  reg [31:0] timer_q;
  reg [7:0] buf_q [0:31];
  reg [31:0] buf_valid_q;
  reg [4:0] walk_q;
  reg [AW-1:0] erase_addr_q;
  reg erasing_q;
  reg sig_target_q;
  reg [7:0] fuse_q;
  reg [7:0] user_row_q [0:31];
  reg mem_we;
  reg [AW-1:0] mem_waddr;
  reg [7:0] mem_wdata;
  wire [7:0] mem_rdata;
  wire step_fall;
  wire strobe_fall;
  wire busy;
  wire [AW-1:0] cur_addr;
  wire cmd_ok;
  integer i;

  assign step_fall = step_q && !offset_step_pin_in;
  assign strobe_fall = strobe_n_q && !load_strobe_pin_n_in;
  assign busy = (state_q == ST_PROG) || (state_q == ST_WAIT);
  assign cur_addr = {page_q[PAGE_BITS-1:0], offset_q};
  // command latched only out of busy; stale code would corrupt a running write
  assign cmd_ok = hv_q && !busy;

  // pin history
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      hv_q <= 1'b0;
      step_q <= 1'b0;
      strobe_n_q <= 1'b1;
      cmd_q <= 4'h0;
    end else begin
      hv_q <= high_voltage_in;
      step_q <= offset_step_pin_in;
      strobe_n_q <= load_strobe_pin_n_in;
      if (cmd_ok) begin
        cmd_q <= command_select_code_in;
      end
    end
  end

  // page register and offset counter
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      page_q <= 8'h00;
      offset_q <= 5'h00;
    end else if (hv_q != high_voltage_in) begin
      offset_q <= 5'h00;
    end else if (cmd_ok && step_fall) begin
      case (command_select_code_in)
        `PFP_CMD_LOAD_PAGE: begin
          page_q <= data_port_in;
          offset_q <= 5'h00;
        end
        `PFP_CMD_CODE_WRITE, `PFP_CMD_CODE_READ, `PFP_CMD_SIG_WRITE, `PFP_CMD_SIG_READ: begin
          offset_q <= offset_q + 5'h01;
        end
        default: begin
          offset_q <= offset_q;
        end
      endcase
    end
  end

  // sequencer
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h0;
      buf_valid_q <= 32'h0;
      walk_q <= 5'h00;
      erasing_q <= 1'b0;
      erase_addr_q <= {AW{1'b0}};
      sig_target_q <= 1'b0;
      fuse_q <= `PFP_FUSE_RESET;
      for (i = 0; i < 32; i = i + 1) begin
        buf_q[i] <= `PFP_ERASED;
        user_row_q[i] <= `PFP_ERASED;
      end
    end else begin
      case (state_q)
        ST_IDLE, ST_LOAD: begin
          if (state_q == ST_LOAD && timer_q == 32'h0) begin
            state_q <= ST_PROG;
            timer_q <= WRITE_CYC - 1;
            walk_q <= 5'h00;
          end else if (state_q == ST_LOAD) begin
            timer_q <= timer_q - 32'h1;
          end
          if (cmd_ok && strobe_fall) begin
            case (command_select_code_in)
              `PFP_CMD_CODE_WRITE, `PFP_CMD_SIG_WRITE: begin
                // user row refused when its fuse disables it
                if (command_select_code_in == `PFP_CMD_CODE_WRITE ||
                    !fuse_q[`PFP_FUSE_USER_ROW_BIT]) begin
                  buf_q[offset_q] <= data_port_in;
                  buf_valid_q[offset_q] <= 1'b1;
                  sig_target_q <= (command_select_code_in == `PFP_CMD_SIG_WRITE);
                  state_q <= ST_LOAD;
                  timer_q <= LOAD_WAIT_CYC - 1;
                end
              end
              `PFP_CMD_ERASE: begin
                state_q <= ST_WAIT;
                timer_q <= ERASE_CYC - 1;
                erasing_q <= 1'b1;
                erase_addr_q <= {AW{1'b0}};
                fuse_q[`PFP_LOCK_TWO_BIT] <= 1'b1;
                fuse_q[`PFP_LOCK_ONE_BIT] <= 1'b1;
                if (!fuse_q[`PFP_FUSE_USER_ROW_BIT]) begin
                  for (i = 0; i < 32; i = i + 1) begin
                    user_row_q[i] <= `PFP_ERASED;
                  end
                end
              end
              `PFP_CMD_FUSE_WRITE: begin
                state_q <= ST_WAIT;
                timer_q <= ERASE_CYC - 1;
                fuse_q <= {data_port_in[7:4], 2'b00, data_port_in[1:0]};
              end
              default: begin
                fuse_q <= fuse_q;
              end
            endcase
          end
        end
        ST_PROG: begin
          // page commit, one buffered byte per cycle, skipped bytes untouched
          if (sig_target_q && buf_valid_q[walk_q]) begin
            user_row_q[walk_q] <= buf_q[walk_q];
          end
          buf_valid_q[walk_q] <= 1'b0;
          walk_q <= walk_q + 5'h01;
          timer_q <= timer_q - 32'h1;
          if (walk_q == 5'h1F) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (erasing_q) begin
            erase_addr_q <= erase_addr_q + {{(AW-1){1'b0}}, 1'b1};
            if (erase_addr_q == {AW{1'b1}}) begin
              erasing_q <= 1'b0;
            end
          end
          if (timer_q == 32'h0) begin
            state_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // code memory write port: page commit or erase walk
  always @* begin
    mem_we = 1'b0;
    mem_waddr = cur_addr;
    mem_wdata = `PFP_ERASED;
    if (state_q == ST_PROG && !sig_target_q && buf_valid_q[walk_q]) begin
      mem_we = 1'b1;
      mem_waddr = {page_q[PAGE_BITS-1:0], walk_q};
      mem_wdata = buf_q[walk_q];
    end else if (state_q == ST_WAIT && erasing_q) begin
      mem_we = 1'b1;
      mem_waddr = erase_addr_q;
    end
  end

  pfp_mem #(
    .AW(AW)
  ) u_mem (
    .clock_in(clock_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_waddr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(cur_addr),
    .rd_data_out(mem_rdata)
  );

  // pins out; read data lags the address by two cycles, well inside verify time
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      data_port_out <= 8'h00;
      data_port_oe_out <= 1'b0;
      busy_output_pin_out <= 1'b0;
      busy_output_pin_oe_out <= 1'b0;
    end else begin
      busy_output_pin_out <= 1'b0;
      busy_output_pin_oe_out <= busy;
      data_port_oe_out <= 1'b0;
      data_port_out <= 8'h00;
      if (hv_q) begin
        case (cmd_q)
          `PFP_CMD_CODE_READ: begin
            data_port_oe_out <= 1'b1;
            data_port_out <= mem_rdata;
          end
          `PFP_CMD_SIG_READ: begin
            data_port_oe_out <= 1'b1;
            if (page_q == `PFP_PAGE_USER) begin
              data_port_out <= user_row_q[offset_q];
            end else if (page_q == `PFP_PAGE_MAKER) begin
              case (offset_q)
                5'h00: data_port_out <= MAKER_ID0;
                5'h01: data_port_out <= MAKER_ID1;
                default: data_port_out <= `PFP_ERASED;
              endcase
            end else begin
              data_port_out <= `PFP_ERASED;
            end
          end
          `PFP_CMD_FUSE_READ: begin
            data_port_oe_out <= 1'b1;
            data_port_out <= {fuse_q[7:4], 2'b00, fuse_q[1:0]};
          end
          default: begin
            data_port_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // pfp_port

// ### verification/pfp_asserts.sv
// Purpose: port assertions of pfp_port
// Assumes: bound from the bench top file
// Notes: busy spans measured by a counter
`timescale 1ns/1ps
module pfp_asserts #(
  parameter WRITE_CYC = 64,
  parameter ERASE_CYC = 8192
) (
  // clock, reset, pins in
  input wire clock_in,
  input wire nrst_in,
  input wire high_voltage_in,
  input wire [3:0] command_select_code_in,
  input wire load_strobe_pin_n_in,
  // pins out
  input wire data_port_oe_out,
  input wire busy_output_pin_out,
  input wire busy_output_pin_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire hv = high_voltage_in;
  wire [3:0] c = command_select_code_in;
  wire bz = busy_output_pin_oe_out;
  wire rd = c == 4'hC || c == 4'h8 || c == 4'h3;
  wire sf = load_strobe_pin_n_in;
  reg [3:0] c1_q, c2_q, k_q;
  reg [1:0] hv_q, bz_q;
  reg [19:0] n_q;
  always @(posedge clock_in) begin
    c1_q <= c;
    c2_q <= c1_q;
    hv_q <= {hv_q[0], hv};
    bz_q <= {bz_q[0], bz};
    n_q <= bz ? n_q + 20'h1 : 20'h0;
    if (!bz) begin
      k_q <= c;
    end
  end
  // three quiet samples so any mode register pipeline has settled
  wire steady = c == c1_q && c == c2_q && hv && hv_q == 2'h3 && !bz && bz_q == 2'h0;
  wire slow = k_q == 4'h1 || k_q == 4'hF;
  busy_drive_low_a: assert property (busy_output_pin_out == 1'b0) else $error("busy pin driven high");
  port_idle_nohv_a: assert property (!hv && hv_q == 2'h0 |=> !data_port_oe_out) else $error("port driven");
  port_write_off_a: assert property (steady && !rd |=> !data_port_oe_out) else $error("port driven in write");
  port_read_on_a: assert property (steady && rd |=> data_port_oe_out) else $error("port idle in read");
  erase_busy_a: assert property ($fell(sf) && c == 4'h1 && steady |-> ##[1:3] bz) else $error("no busy");
  erase_nohv_a: assert property ($fell(sf) && !hv && hv_q == 2'h0 && !bz |=> !bz [*4]) else $error("busy");
  load_wait_a: assert property ($fell(sf) && c == 4'hE && steady |=> !bz [*8]) else $error("early write");
  slow_len_a: assert property ($fell(bz) && slow |-> n_q >= ERASE_CYC && n_q <= ERASE_CYC + 3) else $error("span");
  page_len_a: assert property ($fell(bz) && !slow |-> n_q >= WRITE_CYC && n_q <= WRITE_CYC + 3) else $error("span");
endmodule // pfp_asserts

// ### verification/pfp_prog_model.sv
// Purpose: pin level model of the programmer side
// Assumes: pull-ups on data port and busy pin
// Notes: released lines read high, never the last value
`timescale 1ns/1ps
module pfp_prog_model (
  // device side
  input wire [7:0] dev_data_in,
  input wire dev_oe_in,
  input wire dev_busy_in,
  input wire dev_busy_oe_in,
  // programmer side
  input wire [7:0] prog_data_in,
  input wire prog_oe_in,
  // resolved pins
  output wire [7:0] port_out,
  output wire busy_out
);
  assign port_out = dev_oe_in ? dev_data_in : (prog_oe_in ? prog_data_in : 8'hFF);
  assign busy_out = dev_busy_oe_in ? dev_busy_in : 1'b1;
endmodule // pfp_prog_model

// ### verification/pfp_port_tb.sv
// Purpose: directed bench of pfp_port
// Assumes: times scaled down by parameters
// Notes: pulses shortened to fit the scaled load wait
`timescale 1ns/1ps
module pfp_port_tb;
  localparam [7:0] ID0 = 8'h6B; // arbitrary value
  localparam [7:0] ID1 = 8'h9E; // arbitrary value
  reg clock_in = 1'b0;
  reg nrst_in = 1'b0;
  reg hv = 1'b0;
  reg [3:0] code = 4'h0;
  reg step = 1'b0;
  reg strobe_n = 1'b1;
  reg [7:0] pdata = 8'h00;
  reg pdrive = 1'b0;
  wire [7:0] dout, port;
  wire doe, bout, boe, busy;
  integer fail_count = 0;
  integer n_checks = 0;
  integer i;
  always #2.5 clock_in = ~clock_in;
  pfp_port #(.LOAD_WAIT_CYC(40), .WRITE_CYC(64), .ERASE_CYC(8192), .MAKER_ID0(ID0), .MAKER_ID1(ID1)) dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .high_voltage_in(hv), .command_select_code_in(code),
    .offset_step_pin_in(step), .load_strobe_pin_n_in(strobe_n), .data_port_in(port),
    .data_port_out(dout), .data_port_oe_out(doe), .busy_output_pin_out(bout), .busy_output_pin_oe_out(boe));
  pfp_prog_model prog (.dev_data_in(dout), .dev_oe_in(doe), .dev_busy_in(bout), .dev_busy_oe_in(boe),
    .prog_data_in(pdata), .prog_oe_in(pdrive), .port_out(port), .busy_out(busy));
  task check(input [8*8:1] what, input [7:0] exp, input [7:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(negedge clock_in);
    end
  endtask
  task set_cmd(input [3:0] c);
    begin
      code = c;
      tick(4);
    end
  endtask
  task step_pin;
    begin
      step = 1'b1;
      tick(4);
      step = 1'b0;
      tick(4);
    end
  endtask
  task load_page(input [7:0] p);
    begin
      set_cmd(4'hD);
      pdata = p;
      pdrive = 1'b1;
      step_pin;
      pdrive = 1'b0;
    end
  endtask
  task load_byte(input [7:0] d);
    begin
      pdata = d;
      pdrive = 1'b1;
      tick(2);
      strobe_n = 1'b0;
      tick(4);
      strobe_n = 1'b1;
      tick(2);
      pdrive = 1'b0;
    end
  endtask
  task read_byte(input [7:0] exp);
    begin
      tick(6);
      check("read", exp, port);
      step_pin;
    end
  endtask
  task wait_ready;
    begin
      // a page write stays idle for the load wait first, so let busy start before waiting for its end
      i = 0;
      while (busy === 1'b1 && i < 200) begin
        tick(1);
        i = i + 1;
      end
      i = 0;
      while (busy !== 1'b1 && i < 20000) begin
        tick(1);
        i = i + 1;
      end
      check("ready", 8'h01, {7'h0, busy});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    tick(90000);
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial begin
    tick(5);
    nrst_in = 1'b1;
    set_cmd(4'hC);
    check("idle", 8'hFF, port);
    set_cmd(4'h1);
    load_byte(8'h00);
    check("no hv", 8'h01, {7'h0, busy});
    hv = 1'b1;
    tick(4);
    load_byte(8'h00);
    check("erasing", 8'h00, {7'h0, busy});
    set_cmd(4'hC);
    check("frozen", 8'hFF, port);
    wait_ready;
    set_cmd(4'hF);
    load_byte(8'hB0);
    wait_ready;
    set_cmd(4'h3);
    tick(6);
    check("fuse", 8'hB0, port);
    set_cmd(4'h1);
    load_byte(8'h00);
    wait_ready;
    set_cmd(4'h3);
    tick(6);
    check("unlock", 8'hB3, port);
    load_page(8'h05);
    set_cmd(4'hE);
    load_byte(8'hA1);
    step_pin;
    step_pin;
    load_byte(8'h3C);
    tick(60);
    check("writing", 8'h00, {7'h0, busy});
    wait_ready;
    load_page(8'h05);
    set_cmd(4'hC);
    read_byte(8'hA1);
    read_byte(8'hFF);
    read_byte(8'h3C);
    read_byte(8'hFF);
    for (i = 0; i < 28; i = i + 1)
      step_pin;
    read_byte(8'hA1);
    step_pin;
    hv = 1'b0;
    tick(4);
    hv = 1'b1;
    tick(4);
    read_byte(8'hA1);
    load_page(8'h04);
    set_cmd(4'hC);
    read_byte(8'hFF);
    load_page(8'h00);
    set_cmd(4'h0);
    load_byte(8'h77);
    wait_ready;
    load_page(8'h00);
    set_cmd(4'h8);
    read_byte(8'h77);
    load_page(8'h01);
    set_cmd(4'h8);
    read_byte(ID0);
    read_byte(ID1);
    read_byte(8'hFF);
    set_cmd(4'hF);
    load_byte(8'hF3);
    wait_ready;
    load_page(8'h00);
    set_cmd(4'h0);
    load_byte(8'h11);
    tick(200);
    set_cmd(4'h1);
    load_byte(8'h00);
    wait_ready;
    load_page(8'h00);
    set_cmd(4'h8);
    read_byte(8'h77);
    load_page(8'h05);
    set_cmd(4'hC);
    read_byte(8'hFF);
    hv = 1'b0;
    tick(4);
    check("released", 8'hFF, port);
    print_verdict;
  end
endmodule // pfp_port_tb
bind pfp_port pfp_asserts #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) chk (.*);
